/* src/spsc_agent.sv */
/*
 * agent end: nine requesters, lock, parity fault, system fault, speed strap.
 * assumes the bridge end shares REF_CLK.
 */
`timescale 1ns/1ns
module spsc_agent
   import spsc_pkg::*;
(
   // clock and reset
   input  wire logic                   REF_CLK,
   input  wire logic                   RESET_N,
   // user side
   input  wire logic [SPSC_AGENTS-1:0] WANT_BUS,
   input  wire logic                   LOCK_REQ,
   input  wire logic                   PARITY_FAULT,
   input  wire logic                   SYSTEM_FAULT,
   input  wire logic                   SLOW_ONLY,
   output logic      [SPSC_AGENTS-1:0] GRANTED,
   output logic                        STOP_SEEN,
   output logic                        SEC_IN_RESET,
   // secondary bus
   spsc_if.agent                       bus
);
   logic [SPSC_AGENTS-1:0] req_reg;
   logic lock_a_reg, lock_oe_reg, perr_a_reg, perr_oe_reg, serr_reg, slow_reg;
   logic live;
   assign live = RESET_N & bus.rst_n;
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) req_reg <= '0;
      else          req_reg <= WANT_BUS & {SPSC_AGENTS{bus.rst_n}};
   end
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         lock_a_reg  <= 1'b0;
         lock_oe_reg <= 1'b0;
      end else begin
         lock_a_reg  <= LOCK_REQ & live;
         lock_oe_reg <= (LOCK_REQ & live) | lock_a_reg;
      end
   end
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         perr_a_reg  <= 1'b0;
         perr_oe_reg <= 1'b0;
      end else begin
         perr_a_reg  <= PARITY_FAULT & live;
         perr_oe_reg <= (PARITY_FAULT & live) | perr_a_reg;
      end
   end
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         serr_reg     <= 1'b0;
         slow_reg     <= 1'b0;
         GRANTED      <= '0;
         STOP_SEEN    <= 1'b0;
         SEC_IN_RESET <= 1'b1;
      end else begin
         serr_reg     <= SYSTEM_FAULT & live;
         slow_reg     <= SLOW_ONLY;
         GRANTED      <= ~bus.gnt_n;
         STOP_SEEN    <= ~bus.stop_n;
         SEC_IN_RESET <= ~bus.rst_n;
      end
   end
   assign bus.req_n      = ~req_reg;
   assign bus.lock_a_o_n = ~lock_a_reg;
   assign bus.lock_a_oe  = lock_oe_reg;
   assign bus.perr_a_o_n = ~perr_a_reg;
   assign bus.perr_a_oe  = perr_oe_reg;
   assign bus.serr_a_oe  = serr_reg;
   assign bus.m66_a_oe   = slow_reg;
endmodule : spsc_agent

/* src/spsc_bridge.sv */
/*
 * bridge end: stop, parity fault, reset, arbiter, bus parking, speed sense.
 * assumes the agent end shares REF_CLK and keeps its own release rules.
 */
`timescale 1ns/1ns
module spsc_bridge
   import spsc_pkg::*;
#(
   parameter int AGENTS = SPSC_AGENTS
)(
   // clock and reset
   input  wire logic                   REF_CLK,
   input  wire logic                   RESET_N,
   // core controls
   input  wire logic                   CFG_SEC_RESET,
   input  wire logic                   INTERNAL_ARBITER_ENABLE_N,
   input  wire logic                   TARGET_STOP,
   input  wire logic                   PARITY_CHECK,
   input  wire logic                   PARITY_BAD,
   input  wire logic                   LOCK_REQ,
   input  wire logic                   BUS_IDLE,
   // core status
   output logic                        SYS_FAULT_SEEN,
   output logic                        FAST_CLOCK_OK,
   output logic                        LOCK_SEEN,
   // secondary bus
   spsc_if.bridge                      bus
);
   // ***********************************
   // secondary reset
   // ***********************************
   logic rst_reg;
   logic sec_rst_next;
   // the control logic below is gated by the next reset level, so every control
   // output floats at the very edge on which rst_n falls, not one cycle later
   assign sec_rst_next = CFG_SEC_RESET;
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) rst_reg <= 1'b1;
      else          rst_reg <= sec_rst_next;
   end
   // primary reset reaches the pin without waiting for a clock
   assign bus.rst_n = ~(rst_reg | ~RESET_N);

   // ***********************************
   // release helper: drive inactive one cycle, then float
   // ***********************************
   logic stop_a_reg, stop_oe_reg, perr_a_reg, perr_oe_reg, lock_a_reg, lock_oe_reg;
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         stop_a_reg  <= 1'b0;
         stop_oe_reg <= 1'b0;
      end else if (sec_rst_next) begin
         stop_a_reg  <= 1'b0;
         stop_oe_reg <= 1'b0;
      end else begin
         stop_a_reg  <= TARGET_STOP;
         stop_oe_reg <= TARGET_STOP | stop_a_reg;
      end
   end

   // ***********************************
   // parity fault drive
   // ***********************************
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         perr_a_reg  <= 1'b0;
         perr_oe_reg <= 1'b0;
      end else if (sec_rst_next) begin
         perr_a_reg  <= 1'b0;
         perr_oe_reg <= 1'b0;
      end else begin
         perr_a_reg  <= PARITY_CHECK & PARITY_BAD;
         perr_oe_reg <= (PARITY_CHECK & PARITY_BAD) | perr_a_reg;
      end
   end

   // ***********************************
   // lock drive
   // ***********************************
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         lock_a_reg  <= 1'b0;
         lock_oe_reg <= 1'b0;
      end else if (sec_rst_next) begin
         lock_a_reg  <= 1'b0;
         lock_oe_reg <= 1'b0;
      end else begin
         lock_a_reg  <= LOCK_REQ;
         lock_oe_reg <= LOCK_REQ | lock_a_reg;
      end
   end
   assign bus.stop_o_n   = ~stop_a_reg;
   assign bus.stop_oe    = stop_oe_reg;
   assign bus.perr_b_o_n = ~perr_a_reg;
   assign bus.perr_b_oe  = perr_oe_reg;
   assign bus.lock_b_o_n = ~lock_a_reg;
   assign bus.lock_b_oe  = lock_oe_reg;

   // ***********************************
   // arbiter: agents 0..AGENTS-1 only; the bridge itself takes no grant
   // ***********************************
   typedef enum logic [1:0] {SPSC_ARB_IDLE, SPSC_ARB_GRANT, SPSC_ARB_GAP} spsc_arb_t;
   spsc_arb_t         arb_reg;
   logic [AGENTS-1:0] gnt_reg;
   logic [1:0]        gap_reg;
   logic [3:0]        last_reg;
   logic [3:0]        pick;
   logic              pick_ok;

   // index step places after the last winner, wrapping round the agents;
   // last_reg is four bits wide, so AGENTS must stay at sixteen or below
   function automatic logic [3:0] rr_index(input logic [3:0] last, input int step);
      rr_index = 4'((int'(last) + step) % AGENTS);
   endfunction : rr_index

   // round robin starting after the last winner; the nearest requester wins
   always_comb begin
      pick    = 4'h0;
      pick_ok = 1'b0;
      for (int i = AGENTS; i >= 1; i--) begin
         if (!bus.req_n[rr_index(last_reg, i)]) begin
            pick    = rr_index(last_reg, i);
            pick_ok = 1'b1;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         arb_reg  <= SPSC_ARB_IDLE;
         gnt_reg  <= '0;
         gap_reg  <= 2'h0;
         last_reg <= 4'h0;
      end else if (sec_rst_next || INTERNAL_ARBITER_ENABLE_N) begin
         arb_reg  <= SPSC_ARB_IDLE;
         gnt_reg  <= '0;
         gap_reg  <= 2'h0;
      end else begin
         unique case (arb_reg)
            SPSC_ARB_IDLE: begin
               if (pick_ok) begin
                  gnt_reg  <= AGENTS'(1) << pick;
                  last_reg <= pick;
                  arb_reg  <= SPSC_ARB_GRANT;
               end
            end
            SPSC_ARB_GRANT: begin
               if (bus.req_n[last_reg]) begin
                  gnt_reg <= '0;
                  gap_reg <= SPSC_GAP_LOAD;
                  arb_reg <= SPSC_ARB_GAP;
               end
            end
            SPSC_ARB_GAP: begin
               // two gap cycles plus the idle pick keep a removed grant off three edges
               gap_reg <= gap_reg - 2'h1;
               if (gap_reg == 2'h1) arb_reg <= SPSC_ARB_IDLE;
            end
            default: arb_reg <= SPSC_ARB_IDLE;
         endcase
      end
   end
   // grants float high under reset via the pull-ups, modelled as released
   assign bus.gnt_n = ~gnt_reg;

   // ***********************************
   // parking and reset drive of data lines
   // ***********************************
   logic park_reg;
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) park_reg <= 1'b0;
      else park_reg <= ~sec_rst_next & BUS_IDLE & (gnt_reg == '0) & ~INTERNAL_ARBITER_ENABLE_N;
   end
   // zeros while in reset, idle pattern while parked
   assign bus.ad_b    = SPSC_RST_AD;
   assign bus.cbe_b   = park_reg ? SPSC_IDLE_CBE : SPSC_RST_CBE;
   assign bus.par_b   = 1'b0;
   assign bus.ad_b_oe = ~bus.rst_n | park_reg;

   // ***********************************
   // system fault sense
   // ***********************************
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) SYS_FAULT_SEEN <= 1'b0;
      else          SYS_FAULT_SEEN <= ~bus.serr_n;
   end

   // ***********************************
   // speed sense
   // ***********************************
   // one sample per clock; a strap that changes mid-run shows two cycles late, one in the agent and one here
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) FAST_CLOCK_OK <= 1'b0;
      else          FAST_CLOCK_OK <= bus.m66;
   end
   // bridge never pulls the speed line itself
   assign bus.m66_b_o  = 1'b1;
   assign bus.m66_b_oe = 1'b0;

   // ***********************************
   // lock sense
   // ***********************************
   // seen from either owner, the bridge's own lock included
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) LOCK_SEEN <= 1'b0;
      else          LOCK_SEEN <= ~bus.lock_n;
   end
endmodule : spsc_bridge

/* src/spsc_if.sv */
/*
 * wires of the secondary bus between the bridge end and an agent end.
 * resolves each shared line from the enables; pull-ups give high when undriven.
 */
`timescale 1ns/1ns
interface spsc_if;
   import spsc_pkg::*;
   // bridge-driven
   logic                   stop_o_n, stop_oe;
   logic                   perr_b_o_n, perr_b_oe;
   logic                   lock_b_o_n, lock_b_oe;
   logic [SPSC_AGENTS-1:0] gnt_n;
   logic                   rst_n;
   logic [SPSC_AD_W-1:0]   ad_b;
   logic [SPSC_CBE_W-1:0]  cbe_b;
   logic                   par_b, ad_b_oe;
   logic                   m66_b_o, m66_b_oe;
   // agent-driven
   logic [SPSC_AGENTS-1:0] req_n;
   logic                   perr_a_o_n, perr_a_oe;
   logic                   lock_a_o_n, lock_a_oe;
   logic                   serr_a_oe;
   logic                   m66_a_oe;
   // resolved levels
   logic                   stop_n, perr_n, lock_n, serr_n, m66;
   assign stop_n = stop_oe ? stop_o_n : 1'b1;
   assign perr_n = perr_b_oe ? perr_b_o_n : (perr_a_oe ? perr_a_o_n : 1'b1);
   assign lock_n = lock_b_oe ? lock_b_o_n : (lock_a_oe ? lock_a_o_n : 1'b1);
   assign serr_n = ~serr_a_oe;
   assign m66    = ~((m66_b_oe & ~m66_b_o) | m66_a_oe);
   modport bridge (output stop_o_n, stop_oe, perr_b_o_n, perr_b_oe, lock_b_o_n, lock_b_oe,
                   gnt_n, rst_n, ad_b, cbe_b, par_b, ad_b_oe, m66_b_o, m66_b_oe,
                   input req_n, perr_n, lock_n, serr_n, m66);
   modport agent  (output req_n, perr_a_o_n, perr_a_oe, lock_a_o_n, lock_a_oe, serr_a_oe,
                   m66_a_oe,
                   input gnt_n, rst_n, stop_n, perr_n, lock_n, m66);
endinterface : spsc_if

/* src/spsc_pkg.sv */
/*
 * constants shared by both ends of the secondary pci control link.
 * assumes a single 100 mhz clock common to both ends.
 */
//
// Operation
// - bridge target asserts stop to end transaction
// - stop driver drives inactive one cycle before release
// - master holds lock across atomic transaction sequence
// - bridge asserts parity fault on received data error
// - parity fault driven inactive one cycle before release
// - system fault is open-drain input from any agent
// - nine agents request; each has matching grant
// - removed grant stays inactive two clocks minimum
// - primary reset asserts secondary reset
// - zeros on data, command, parity during reset
// - fast clock enable high allows 66, low 33
// - config reset bit also asserts secondary reset
// - control outputs released while secondary reset asserted; agent outputs other than the speed strap stay driven up to two cycles after rst_n falls
// - idle bus with own grant: bridge parks bus
// - arbiter enable high means external arbiter used
package spsc_pkg;
   // ***********************************
   // sizes
   // ***********************************
   localparam int          SPSC_AGENTS     = 9;
   localparam int          SPSC_AD_W       = 32;
   localparam int          SPSC_CBE_W      = 4;
   // ***********************************
   // timing and bus values
   // ***********************************
   localparam int          SPSC_GNT_GAP    = 2;
   localparam logic [1:0]  SPSC_GAP_LOAD   = 2'h2;
   localparam logic [31:0] SPSC_RST_AD     = 32'h0000_0000;
   localparam logic [3:0]  SPSC_RST_CBE    = 4'h0;
   localparam logic [3:0]  SPSC_IDLE_CBE   = 4'h0;
endpackage : spsc_pkg

/* tb/spsc_assertions.sv */
/*
 * timing checks on the secondary bus wires between the bridge end and the agent end.
 * assumes it is instantiated beside the interface and shares REF_CLK and RESET_N.
 */
`timescale 1ns/1ns
module spsc_assertions
   import spsc_pkg::*;
(
   // clock and reset
   input wire logic                   REF_CLK,
   input wire logic                   RESET_N,
   // interface wires
   input wire logic                   stop_o_n,
   input wire logic                   stop_oe,
   input wire logic                   perr_b_o_n,
   input wire logic                   perr_b_oe,
   input wire logic [SPSC_AGENTS-1:0] gnt_n,
   input wire logic [SPSC_AGENTS-1:0] req_n,
   input wire logic                   rst_n,
   input wire logic [SPSC_AD_W-1:0]   ad_b,
   input wire logic [SPSC_CBE_W-1:0]  cbe_b,
   input wire logic                   par_b,
   input wire logic                   ad_b_oe
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);
   property p_stop_rel;
      $fell(stop_oe) && rst_n |-> $past(stop_o_n);
   endproperty
   a_stop_rel: assert property (p_stop_rel) else $error("stop released while low");
   property p_stop_one;
      stop_oe && stop_o_n |=> !stop_oe;
   endproperty
   a_stop_one: assert property (p_stop_one) else $error("stop high beyond one cycle");
   property p_perr_rel;
      $fell(perr_b_oe) |-> $past(perr_b_o_n);
   endproperty
   a_perr_rel: assert property (p_perr_rel) else $error("parity fault released while low");
   property p_one_gnt;
      $onehot0(~gnt_n);
   endproperty
   a_one_gnt: assert property (p_one_gnt) else $error("two grants at once");
   // the arbiter gap is global, so every grant stays off after the granted agent drops its request
   property p_gnt_gap;
      |(gnt_n & ~$past(gnt_n)) |=> (&gnt_n) [*2];
   endproperty
   a_gnt_gap: assert property (p_gnt_gap) else $error("grant inside the gap");
   property p_gnt_req;
      (~gnt_n & $past(req_n)) == '0;
   endproperty
   a_gnt_req: assert property (p_gnt_req) else $error("grant without request");
   property p_rst_follow;
      disable iff (1'b0) !RESET_N |-> !rst_n;
   endproperty
   a_rst_follow: assert property (p_rst_follow) else $error("secondary reset not following");
   property p_rst_zero;
      disable iff (1'b0) !rst_n ##1 !rst_n |-> ad_b == '0 && cbe_b == '0 && !par_b && ad_b_oe;
   endproperty
   a_rst_zero: assert property (p_rst_zero) else $error("data lines not zero in reset");
   property p_rst_float;
      !rst_n |-> !stop_oe && !perr_b_oe && &gnt_n;
   endproperty
   a_rst_float: assert property (p_rst_float) else $error("control driven in reset");
endmodule : spsc_assertions

/* tb/test_secondary_pci_side_control.sv */
/*
 * self-checking bench: bridge end and agent end joined by the bus interface.
 * assumes all user inputs are levels sampled on REF_CLK rising edges.
 */
`timescale 1ns/1ns
module test_secondary_pci_side_control
   import spsc_pkg::*;
;
   logic                   REF_CLK = 1'b0;
   logic                   RESET_N = 1'b0;
   logic                   cfg_rst = 1'b0, arb_off_n = 1'b0, tstop = 1'b0, pchk = 1'b0, pbad = 1'b0;
   logic                   b_lock = 1'b0, idle = 1'b1, a_lock = 1'b0, sfault = 1'b0, slow = 1'b0;
   logic                   afault = 1'b0;
   logic [SPSC_AGENTS-1:0] want = '0;
   logic [SPSC_AGENTS-1:0] granted;
   logic                   sys_seen, fast_ok, lock_seen, stop_seen, in_rst;
   int                     fail_count = 0;
   int                     cmp_count = 0;
   always #5 REF_CLK = ~REF_CLK;
   spsc_if spsc_if_i ();
   spsc_bridge spsc_bridge_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .CFG_SEC_RESET(cfg_rst),
      .INTERNAL_ARBITER_ENABLE_N(arb_off_n), .TARGET_STOP(tstop), .PARITY_CHECK(pchk), .PARITY_BAD(pbad),
      .LOCK_REQ(b_lock), .BUS_IDLE(idle), .SYS_FAULT_SEEN(sys_seen), .FAST_CLOCK_OK(fast_ok),
      .LOCK_SEEN(lock_seen), .bus(spsc_if_i));
   spsc_agent spsc_agent_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .WANT_BUS(want), .LOCK_REQ(a_lock),
      .PARITY_FAULT(afault), .SYSTEM_FAULT(sfault), .SLOW_ONLY(slow), .GRANTED(granted),
      .STOP_SEEN(stop_seen), .SEC_IN_RESET(in_rst), .bus(spsc_if_i));
   spsc_assertions spsc_assertions_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .stop_o_n(spsc_if_i.stop_o_n),
      .stop_oe(spsc_if_i.stop_oe), .perr_b_o_n(spsc_if_i.perr_b_o_n), .perr_b_oe(spsc_if_i.perr_b_oe),
      .gnt_n(spsc_if_i.gnt_n), .req_n(spsc_if_i.req_n), .rst_n(spsc_if_i.rst_n), .ad_b(spsc_if_i.ad_b),
      .cbe_b(spsc_if_i.cbe_b), .par_b(spsc_if_i.par_b), .ad_b_oe(spsc_if_i.ad_b_oe));
   // ***********************************
   // tasks
   // ***********************************
   task automatic tick(input int n);
      repeat (n) @(negedge REF_CLK);
   endtask : tick
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic done(input string name);
      $display("test %s done, mismatches %0d", name, fail_count);
   endtask : done
   task automatic report_and_stop;
      $display("compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic do_reset;
      RESET_N = 1'b0;
      tick(10);
      chk(spsc_if_i.rst_n, 0, "reset out");
      chk(spsc_if_i.ad_b, 0, "reset data");
      RESET_N = 1'b1;
      tick(3);
      chk(spsc_if_i.rst_n, 1, "reset end");
   endtask : do_reset
   // bounded wait: a grant that never comes shows up as a mismatch below
   task automatic grab(input int i);
      int n;
      n = 0;
      want[i] = 1'b1;
      while (granted[i] !== 1'b1 && n < 8) begin
         tick(1);
         n++;
      end
      chk(spsc_if_i.gnt_n, {23'h0, ~(9'h001 << i)}, "grant line");
      chk(granted, 32'h1 << i, "granted");
   endtask : grab
   // ***********************************
   // tests
   // ***********************************
   initial begin
      do_reset();
      chk(spsc_if_i.ad_b_oe, 1, "park");
      chk(spsc_if_i.cbe_b, 0, "park cmd");
      idle = 1'b0;
      tick(2);
      chk(spsc_if_i.ad_b_oe, 0, "unparked while busy");
      idle = 1'b1;
      done("reset");
      for (int i = 0; i < SPSC_AGENTS; i++) begin
         grab(i);
         want[i] = 1'b0;
         if (i < SPSC_AGENTS - 1) want[i + 1] = 1'b1;
         tick(3);
         chk(spsc_if_i.gnt_n, 32'h1ff, "gap");
      end
      arb_off_n = 1'b1;
      want[2] = 1'b1;
      tick(5);
      chk(spsc_if_i.gnt_n, 32'h1ff, "arbiter off");
      want = '0;
      arb_off_n = 1'b0;
      done("arbiter");
      tstop = 1'b1;
      tick(3);
      chk(spsc_if_i.stop_n, 0, "stop low");
      chk(stop_seen, 1, "stop seen");
      tstop = 1'b0;
      tick(1);
      chk(spsc_if_i.stop_oe, 1, "stop driven high");
      chk(spsc_if_i.stop_n, 1, "stop inactive");
      tick(3);
      chk(spsc_if_i.stop_oe, 0, "stop off");
      pchk = 1'b1;
      pbad = 1'b1;
      tick(3);
      chk(spsc_if_i.perr_n, 0, "parity fault");
      pbad = 1'b0;
      tick(1);
      chk(spsc_if_i.perr_b_oe, 1, "parity driven high");
      chk(spsc_if_i.perr_n, 1, "parity inactive");
      tick(3);
      chk(spsc_if_i.perr_b_oe, 0, "parity off");
      done("stop_parity");
      a_lock = 1'b1;
      sfault = 1'b1;
      slow = 1'b1;
      afault = 1'b1;
      tick(4);
      chk(lock_seen, 1, "lock");
      chk(sys_seen, 1, "sys fault");
      chk(fast_ok, 0, "slow");
      chk(spsc_if_i.perr_n, 0, "agent parity fault");
      a_lock = 1'b0;
      sfault = 1'b0;
      slow = 1'b0;
      afault = 1'b0;
      tick(4);
      chk(sys_seen, 0, "sys clear");
      chk(fast_ok, 1, "fast");
      chk(spsc_if_i.perr_a_oe, 0, "agent parity off");
      b_lock = 1'b1;
      tick(3);
      chk(spsc_if_i.lock_n, 0, "bridge lock");
      b_lock = 1'b0;
      tick(4);
      chk(spsc_if_i.lock_b_oe, 0, "bridge lock off");
      done("faults");
      tstop = 1'b1;
      want[3] = 1'b1;
      tick(4);
      chk(spsc_if_i.gnt_n, 32'h1f7, "grant before reset");
      cfg_rst = 1'b1;
      tick(4);
      chk(spsc_if_i.rst_n, 0, "cfg reset");
      chk(in_rst, 1, "agent in reset");
      chk(spsc_if_i.stop_oe, 0, "released");
      chk(spsc_if_i.gnt_n, 32'h1ff, "grants off in reset");
      tstop = 1'b0;
      want = '0;
      cfg_rst = 1'b0;
      tick(4);
      chk(spsc_if_i.rst_n, 1, "cfg end");
      do_reset();
      done("resets");
      report_and_stop();
   end
   initial begin
      repeat (3000) @(posedge REF_CLK);
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop();
   end
endmodule : test_secondary_pci_side_control
